// File: verilog/pbsp_pkg.sv
`default_nettype none
package pbsp_pkg;

	// --------------------------------------------------------------
	// Geometry of the array and the pins
	// --------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam int HI_W = 15;
	localparam int CNT_W = 2;
	localparam int DATA_W = 32;
	localparam int PAR_W = 4;
	localparam int BYTES = 4;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int DEPTH = 131072;

	// --------------------------------------------------------------
	// Burst counter constants
	// --------------------------------------------------------------
	localparam logic [CNT_W-1:0] CNT_START = 2'h0;
	localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
	localparam logic MODE_LINEAR = 1'b0;

	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_DESEL,
		CYC_READ,
		CYC_WRITE
	} pbsp_cycle_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic padsp_n;
		logic cadsp_n;
		logic adv_n;
		logic [BYTES-1:0] bw_n;
		logic bwe_n;
		logic gw_n;
		logic ce1_n;
		logic ce2;
		logic ce3_n;
		logic [DATA_W-1:0] dq;
		logic [PAR_W-1:0] dp;
	} pbsp_in_s;

	typedef struct packed {
		pbsp_in_s in;
		logic [HI_W-1:0] hi;
		logic [CNT_W-1:0] base;
		logic [CNT_W-1:0] count;
		logic active;
		logic desel;
		logic [DATA_W-1:0] rd_dq;
		logic [PAR_W-1:0] rd_dp;
		logic rd_valid;
		logic mask;
		logic out_en;
	} pbsp_state_s;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam pbsp_in_s PBSP_IN_RST = '{
		addr: 17'h00000,
		padsp_n: 1'h1,
		cadsp_n: 1'h1,
		adv_n: 1'h1,
		bw_n: 4'hf,
		bwe_n: 1'h1,
		gw_n: 1'h1,
		ce1_n: 1'h1,
		ce2: 1'h0,
		ce3_n: 1'h1,
		dq: 32'h00000000,
		dp: 4'h0
	};

	localparam pbsp_state_s PBSP_STATE_RST = '{
		in: PBSP_IN_RST,
		hi: 15'h0000,
		base: 2'h0,
		count: 2'h0,
		active: 1'h0,
		desel: 1'h1,
		rd_dq: 32'h00000000,
		rd_dp: 4'h0,
		rd_valid: 1'h0,
		mask: 1'h0,
		out_en: 1'h0
	};

endpackage
`default_nettype wire

// File: verilog/pbsp_burst_seq.sv
`timescale 1ns/1ps
`default_nettype none
module pbsp_burst_seq (
	input wire logic [pbsp_pkg::CNT_W-1:0] start_lo,
	input wire logic [pbsp_pkg::CNT_W-1:0] count,
	input wire logic burst_order_mode,
	output logic [pbsp_pkg::CNT_W-1:0] offset
);
	import pbsp_pkg::*;

	// --------------------------------------------------------------
	// Burst offset
	// --------------------------------------------------------------
	// The strap is only meant to be static, so it is used unregistered.
	always_comb begin
		if (burst_order_mode == MODE_LINEAR) begin
			offset = start_lo + count;
		end else begin
			offset = start_lo ^ count;
		end
	end

endmodule
`default_nettype wire

// File: verilog/pbsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module pbsp_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [pbsp_pkg::ADDR_W-1:0] addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic [pbsp_pkg::BYTES-1:0] byte_write_select_n,
	input wire logic byte_write_qualifier_n,
	input wire logic global_write_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic output_enable_n,
	input wire logic burst_order_mode,
	input wire logic [pbsp_pkg::DATA_W-1:0] dq_in,
	input wire logic [pbsp_pkg::PAR_W-1:0] parity_lines_in,
	output logic [pbsp_pkg::DATA_W-1:0] dq_out,
	output logic [pbsp_pkg::PAR_W-1:0] parity_lines_out,
	output logic dq_oe,
	output logic parity_lines_oe
);
	import pbsp_pkg::*;

	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	// Each lane keeps a parity bit above its data byte.
	logic [BYTES-1:0][LANE_W-1:0] mem_q [DEPTH];

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	pbsp_state_s s_q;
	pbsp_state_s s_d;

	// --------------------------------------------------------------
	// Cycle decode signals
	// --------------------------------------------------------------
	logic selected;
	logic proc_go;
	logic ctrl_go;
	logic start;
	pbsp_cycle_e kind;
	logic [HI_W-1:0] nxt_hi;
	logic [CNT_W-1:0] nxt_base;
	logic [CNT_W-1:0] nxt_count;
	logic nxt_active;
	logic [CNT_W-1:0] offset;
	logic [ADDR_W-1:0] acc_addr;
	logic [BYTES-1:0] wr_lanes;
	logic wr_en;
	logic [BYTES-1:0][LANE_W-1:0] rd_word;
	logic [BYTES-1:0][LANE_W-1:0] wr_word;

	// --------------------------------------------------------------
	// Write lane decode
	// --------------------------------------------------------------
	function automatic logic [BYTES-1:0] lanes_of(
		input logic gw_n,
		input logic bwe_n,
		input logic [BYTES-1:0] bw_n
	);
		logic [BYTES-1:0] lanes;
		lanes = {BYTES{1'b0}};
		if (!gw_n) begin
			lanes = {BYTES{1'b1}};
		end else if (!bwe_n) begin
			lanes = ~bw_n;
		end
		return lanes;
	endfunction

	// --------------------------------------------------------------
	// Chip select decode
	// --------------------------------------------------------------
	// Only the second select is active high; all three must agree at
	// the same edge, or a controller strobe turns into a deselect; a processor strobe with the first select high is ignored.
	function automatic logic is_selected(
		input logic ce1_n,
		input logic ce2,
		input logic ce3_n
	);
		return !ce1_n && ce2 && !ce3_n;
	endfunction

	// --------------------------------------------------------------
	// Burst counter step
	// --------------------------------------------------------------
	// Two bits wide on purpose: the count wraps after the fourth word
	// with no compare, so a burst never leaves its aligned group.
	function automatic logic [CNT_W-1:0] step_of(
		input logic [CNT_W-1:0] count
	);
		return count + CNT_STEP;
	endfunction

	// --------------------------------------------------------------
	// Lane packing
	// --------------------------------------------------------------
	// A parity bit rides above its byte, so a lane write or read
	// always moves the byte and its parity together.
	function automatic logic [BYTES-1:0][LANE_W-1:0] pack_word(
		input logic [DATA_W-1:0] dq,
		input logic [PAR_W-1:0] dp
	);
		logic [BYTES-1:0][LANE_W-1:0] word;
		for (int i = 0; i < BYTES; i++) begin
			word[i] = {dp[i], dq[i*BYTE_W +: BYTE_W]};
		end
		return word;
	endfunction

	// Reads unpack the same way, lane i back onto byte i and parity i.
	function automatic logic [DATA_W-1:0] data_of(
		input logic [BYTES-1:0][LANE_W-1:0] word
	);
		logic [DATA_W-1:0] dq;
		for (int i = 0; i < BYTES; i++) begin
			dq[i*BYTE_W +: BYTE_W] = word[i][BYTE_W-1:0];
		end
		return dq;
	endfunction

	function automatic logic [PAR_W-1:0] parity_of(
		input logic [BYTES-1:0][LANE_W-1:0] word
	);
		logic [PAR_W-1:0] dp;
		for (int i = 0; i < BYTES; i++) begin
			dp[i] = word[i][BYTE_W];
		end
		return dp;
	endfunction

	// --------------------------------------------------------------
	// Access decode on the registered inputs
	// --------------------------------------------------------------
	// Every decision below looks at s_q.in, never at the pins, so a
	// control is acted on exactly one edge after it was sampled.
	always_comb begin
		selected = is_selected(s_q.in.ce1_n, s_q.in.ce2,
			s_q.in.ce3_n);
		proc_go = !s_q.in.padsp_n && !s_q.in.ce1_n;
		ctrl_go = !s_q.in.cadsp_n;
		start = 1'b0;
		kind = CYC_IDLE;
		nxt_hi = s_q.hi;
		nxt_base = s_q.base;
		nxt_count = s_q.count;
		nxt_active = s_q.active;
		// Both strobes lead to the same capture and are simply ORed, so neither
		// has priority; they differ only in the processor strobe's chip-select gating.
		if (proc_go || ctrl_go) begin
			if (selected) begin
				start = 1'b1;
			end else begin
				kind = CYC_DESEL;
			end
		end
		if (start) begin
			nxt_hi = s_q.in.addr[ADDR_W-1:CNT_W];
			nxt_base = s_q.in.addr[CNT_W-1:0];
			nxt_count = CNT_START;
			nxt_active = 1'b1;
		end else if (kind == CYC_DESEL) begin
			nxt_active = 1'b0;
		end else if (s_q.active && !s_q.in.adv_n) begin
			nxt_count = step_of(s_q.count);
		end
		wr_lanes = lanes_of(s_q.in.gw_n, s_q.in.bwe_n, s_q.in.bw_n);
		if (start || (kind == CYC_IDLE && s_q.active)) begin
			if (|wr_lanes) begin
				kind = CYC_WRITE;
			end else begin
				kind = CYC_READ;
			end
		end
	end

	// --------------------------------------------------------------
	// Burst address
	// --------------------------------------------------------------
	pbsp_burst_seq u_seq (
		.start_lo(nxt_base),
		.count(nxt_count),
		.burst_order_mode(burst_order_mode),
		.offset(offset)
	);

	// --------------------------------------------------------------
	// Array port
	// --------------------------------------------------------------
	always_comb begin
		acc_addr = {nxt_hi, offset};
		wr_en = (kind == CYC_WRITE);
		// The array is read with the address of the cycle being decoded;
		// the word reaches the pins from the output register one edge on.
		rd_word = mem_q[acc_addr];
		wr_word = pack_word(s_q.in.dq, s_q.in.dp);
	end

	// The write is finished in the edge that ends the decode cycle,
	// with no strobe from outside beyond the sampled controls.
	always_ff @(posedge clk) begin
		if (resetn && wr_en) begin
			for (int i = 0; i < BYTES; i++) begin
				if (wr_lanes[i]) begin
					mem_q[acc_addr][i] <= wr_word[i];
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.in.addr = addr;
		s_d.in.padsp_n = processor_addr_strobe_n;
		s_d.in.cadsp_n = controller_addr_strobe_n;
		s_d.in.adv_n = burst_advance_n;
		s_d.in.bw_n = byte_write_select_n;
		s_d.in.bwe_n = byte_write_qualifier_n;
		s_d.in.gw_n = global_write_n;
		s_d.in.ce1_n = chip_select_first_n;
		s_d.in.ce2 = chip_select_second;
		s_d.in.ce3_n = chip_select_third_n;
		s_d.in.dq = dq_in;
		s_d.in.dp = parity_lines_in;
		s_d.hi = nxt_hi;
		s_d.base = nxt_base;
		s_d.count = nxt_count;
		s_d.active = nxt_active;
		s_d.rd_valid = 1'b0;
		s_d.mask = 1'b0;
		s_d.out_en = 1'b0;
		case (kind)
			CYC_READ: begin
				s_d.rd_dq = data_of(rd_word);
				s_d.rd_dp = parity_of(rd_word);
				s_d.rd_valid = 1'b1;
				s_d.mask = s_q.desel;
				s_d.out_en = !output_enable_n && !s_q.desel;
				s_d.desel = 1'b0;
			end
			CYC_WRITE: begin
				s_d.desel = 1'b0;
			end
			CYC_DESEL: begin
				s_d.desel = 1'b1;
			end
			CYC_IDLE: begin
				s_d.desel = s_q.desel;
			end
			default: begin
				s_d.desel = 1'b1;
			end
		endcase
		// A read that is already in the output register has its valid flag
		// cleared here when no read and no strobe follows, unless it is the masked first read.
		if (kind != CYC_READ && s_q.rd_valid && !s_q.mask &&
			!(proc_go || ctrl_go)) begin
			s_d.rd_valid = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= PBSP_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	// The enable is taken through a flop, so the pin reacts one edge
	// late; this trades the asynchronous path for a clean single clock.
	always_comb begin
		dq_out = s_q.rd_dq;
		parity_lines_out = s_q.rd_dp;
		dq_oe = s_q.out_en;
		parity_lines_oe = s_q.out_en;
	end

endmodule
`default_nettype wire

// File: sim/pbsp_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pbsp_top_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic [pbsp_pkg::BYTES-1:0] byte_write_select_n,
	input wire logic byte_write_qualifier_n,
	input wire logic global_write_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic output_enable_n,
	input wire logic [pbsp_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic parity_lines_oe
);
	import pbsp_pkg::*;
	// ------------------------------------------------------------
	// Decoded cycle kinds
	// ------------------------------------------------------------
	logic sel, stb, go, off, rdc, idle;
	assign sel = !chip_select_first_n && chip_select_second &&
		!chip_select_third_n;
	assign stb = !controller_addr_strobe_n ||
		(!processor_addr_strobe_n && !chip_select_first_n);
	assign go = stb && sel;
	assign off = stb && !sel;
	assign rdc = global_write_n && byte_write_qualifier_n;
	assign idle = processor_addr_strobe_n && controller_addr_strobe_n &&
		burst_advance_n && rdc;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_oe_pair: assert property (dq_oe == parity_lines_oe)
		else $error("data and parity enables differ");
	a_oe_needs_enable: assert property (dq_oe |-> !$past(output_enable_n))
		else $error("drive without output enable");
	a_write_no_drive: assert property (go && !global_write_n |-> ##2 !dq_oe)
		else $error("drive after global write");
	a_byte_no_drive: assert property
		(go && !byte_write_qualifier_n && !(&byte_write_select_n) |-> ##2 !dq_oe)
		else $error("drive after byte write");
	a_desel_no_drive: assert property (off |-> ##2 !dq_oe)
		else $error("drive after deselect");
	a_first_masked: assert property (off ##1 (go && rdc) |-> ##2 !dq_oe)
		else $error("first read after deselect not masked");
	a_burst_drives: assert property
		((go && rdc) ##1 (!stb && rdc) ##1
		!output_enable_n |=> dq_oe)
		else $error("burst read not driven");
	a_hold_data: assert property (idle ##1 idle |-> ##2 $stable(dq_out))
		else $error("read data moved without advance");
	a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !dq_oe)
		else $error("drive during reset");
	c_desel_read: cover property (off ##1 go);
	c_burst_step: cover property (dq_oe && !burst_advance_n);
	c_drive_rise: cover property ($rose(dq_oe));
endmodule
bind pbsp_top pbsp_top_monitor i_mon (.clk, .resetn, .processor_addr_strobe_n,
	.controller_addr_strobe_n, .burst_advance_n, .byte_write_select_n,
	.byte_write_qualifier_n, .global_write_n, .chip_select_first_n,
	.chip_select_second, .chip_select_third_n, .output_enable_n, .dq_out,
	.dq_oe, .parity_lines_oe);
`default_nettype wire

// File: sim/pbsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbsp_host_model (
	input wire logic clk,
	output logic [pbsp_pkg::ADDR_W-1:0] addr,
	output logic processor_addr_strobe_n,
	output logic controller_addr_strobe_n,
	output logic burst_advance_n,
	output logic [pbsp_pkg::BYTES-1:0] byte_write_select_n,
	output logic byte_write_qualifier_n,
	output logic global_write_n,
	output logic chip_select_first_n,
	output logic chip_select_second,
	output logic chip_select_third_n,
	output logic output_enable_n,
	output logic [pbsp_pkg::DATA_W-1:0] dq_in,
	output logic [pbsp_pkg::PAR_W-1:0] parity_lines_in
);
	import pbsp_pkg::*;
	// ------------------------------------------------------------
	// One bus cycle, launched just after a rising edge
	// ------------------------------------------------------------
	logic oe_n;
	initial begin
		oe_n = 1'b0;
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
			global_write_n, byte_write_qualifier_n, chip_select_first_n,
			byte_write_select_n} = '1;
		{addr, chip_select_second, chip_select_third_n, output_enable_n,
			dq_in, parity_lines_in} = '0;
	end
	task automatic put(input logic [1:0] s, input logic [1:0] w,
		input logic [2:0] ce, input logic av, input logic [ADDR_W-1:0] a,
		input logic [35:0] d, input logic [3:0] bw);
		@(posedge clk);
		#1;
		controller_addr_strobe_n = !s[0];
		processor_addr_strobe_n = !s[1];
		global_write_n = (w != 2'd1);
		byte_write_qualifier_n = (w != 2'd2);
		byte_write_select_n = w[1] ? bw : 4'hf;
		{chip_select_first_n, chip_select_second, chip_select_third_n} = ce;
		burst_advance_n = av;
		addr = a;
		output_enable_n = oe_n;
		// A released data bus must not look like the word it carried in the cycle before.
		{parity_lines_in, dq_in} = (w != 2'd0) ? d : ~{parity_lines_in, dq_in};
	endtask
endmodule
`default_nettype wire

// File: sim/pbsp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pbsp_top_tb;
	import pbsp_pkg::*;
	logic clk, resetn, burst_order_mode;
	logic [ADDR_W-1:0] addr;
	logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
	logic [BYTES-1:0] byte_write_select_n;
	logic byte_write_qualifier_n, global_write_n, output_enable_n;
	logic chip_select_first_n, chip_select_second, chip_select_third_n;
	logic [DATA_W-1:0] dq_in, dq_out;
	logic [PAR_W-1:0] parity_lines_in, parity_lines_out;
	logic dq_oe, parity_lines_oe;
	int bad_count = 0;
	int tests_run = 0;
	logic [35:0] mem [4];
	localparam logic [ADDR_W-1:0] BASE = 17'h12340;
	pbsp_top i_pbsp_top (.*);
	pbsp_host_model i_host (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Compare, report and burst read helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [35:0] exp,
		input logic [35:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Reads mem[st^cnt] or mem[st+cnt]; advance pattern is for drives 1..3.
	task automatic rd(input logic [1:0] s, input logic [1:0] st,
		input logic [2:0] adv_n, input logic masked);
		logic [1:0] cnt;
		logic [1:0] o;
		logic drv;
		cnt = 2'd0;
		for (int i = 0; i < 6; i++) begin
			i_host.put(i == 0 ? s : 2'd0, 2'd0, 3'b010,
				(i >= 1 && i <= 3) ? adv_n[i-1] : 1'b1, BASE + 17'(st), '0, 4'hf);
			if (i >= 2) begin
				o = burst_order_mode ? st ^ cnt : st + cnt;
				check("read word", mem[o], {parity_lines_out, dq_out});
				drv = !(masked && i == 2) && !i_host.oe_n;
				check("read drive", {35'h0, drv}, {35'h0, dq_oe});
				check("parity drive", {35'h0, drv},
					{35'h0, parity_lines_oe});
				if (i < 5 && !adv_n[i-2])
					cnt++;
			end
		end
	endtask
	initial begin
		#100us;
		bad_count++;
		summarize();
	end
	initial begin
		resetn = 1'b0;
		burst_order_mode = 1'b1;
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		check("reset drive", 36'h0, {35'h0, dq_oe});
		for (int i = 0; i < 4; i++) begin
			mem[i] = 36'h9_8765_4321 * 36'(i + 1);
			i_host.put(i[0] ? 2'd2 : 2'd1, 2'd1, 3'b010, 1'b1, BASE + 17'(i),
				mem[i], 4'h0);
		end
		i_host.put(2'd1, 2'd3, 3'b010, 1'b1, BASE + 17'd1, '0, 4'h0);
		i_host.put(2'd1, 2'd2, 3'b010, 1'b1, BASE + 17'd2, '1, 4'ha);
		mem[2] = {mem[2][35], 1'b1, mem[2][33], 1'b1, mem[2][31:24], 8'hff,
			mem[2][15:8], 8'hff};
		// Ignored strobe leaves the burst running, so this writes mem[2].
		i_host.put(2'd2, 2'd1, 3'b110, 1'b1, BASE, 36'h0_a5a5_a5a5, 4'hf);
		mem[2] = 36'h0_a5a5_a5a5;
		i_host.put(2'd1, 2'd1, 3'b000, 1'b1, BASE, '1, 4'hf);
		rd(2'd1, 2'd1, 3'b000, 1'b1);
		// The strap is static: it moves only once a deselect closed the burst.
		repeat (2)
			i_host.put(2'd1, 2'd0, 3'b000, 1'b1, BASE, '0, 4'hf);
		burst_order_mode = 1'b0;
		rd(2'd2, 2'd3, 3'b010, 1'b1);
		i_host.oe_n = 1'b1;
		rd(2'd3, 2'd0, 3'b000, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
